// >>> bench/atg_gate_checker.sv
// Port-level assertions for the translation gate
`timescale 1ns/100ps
`include "atg_defs.vh"
module atg_gate_checker (
	// Clock and reset
	input wire clk_sys, nrst,
	// Accelerator side
	input wire afu_req_valid, afu_req_ready, afu_rsp_fault,
	input wire [47:0] afu_req_va,
	// Translation side
	input wire ats_req_valid, ats_req_ready, ats_cpl_valid, ats_cpl_ok,
	input wire [2:0] ats_req_vc, ats_cpl_vc,
	input wire [1:0] ats_cpl_memtype,
	// Invalidation side
	input wire inv_req_valid, inv_req_ready, inv_cpl_valid, inv_cpl_ready, pcie_inv_done,
	input wire [2:0] inv_req_vc, inv_cpl_vc,
	input wire [4:0] inv_req_tag, inv_cpl_tag,
	// Link side
	input wire link_req_valid, link_req_cacheable,
	input wire [47:0] link_req_pa,
	input wire [1:0] link_req_memtype
);
	reg        inv_busy_reg, pend_reg;
	reg [47:0] va_reg;
	reg [4:0]  tag_reg;
	wire afu_take = afu_req_valid && afu_req_ready;
	wire inv_take = inv_req_valid && inv_req_ready && inv_req_vc == `ATG_VC_ATS;
	wire cpl_take = ats_cpl_valid && ats_cpl_vc == `ATG_VC_ATS && pend_reg;
	// Open invalidation, open translation, last request and tag
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			{inv_busy_reg, pend_reg, va_reg, tag_reg} <= 55'h0;
		end else begin
			if (inv_take) begin
				inv_busy_reg <= 1'b1;
				tag_reg <= inv_req_tag;
			end else if (inv_cpl_valid && inv_cpl_ready) begin
				inv_busy_reg <= 1'b0;
			end
			if (ats_req_valid && ats_req_ready) begin
				pend_reg <= 1'b1;
			end else if (cpl_take) begin
				pend_reg <= 1'b0;
			end
			if (afu_take) begin
				va_reg <= afu_req_va;
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	ats_chan_a: assert property (ats_req_valid |-> ats_req_vc == `ATG_VC_ATS)
		else $error("translation channel");
	cpl_chan_a: assert property (inv_cpl_valid |-> inv_cpl_vc != `ATG_VC_COH)
		else $error("completion channel");
	cpl_gate_a: assert property ($rose(inv_cpl_valid) |-> $past(pcie_inv_done))
		else $error("completion early");
	link_block_a: assert property (inv_busy_reg |-> !link_req_valid)
		else $error("issue during invalidation");
	cpl_delay_a: assert property (inv_take |=> !inv_cpl_valid)
		else $error("completion too soon");
	cpl_tag_a: assert property (inv_cpl_valid |-> inv_cpl_tag == tag_reg)
		else $error("completion tag");
	fault_pulse_a: assert property (cpl_take && (!ats_cpl_ok || ats_cpl_memtype == `ATG_MT_RSVD) |=> afu_rsp_fault)
		else $error("fault missing");
	cache_kind_a: assert property (link_req_valid |-> link_req_cacheable == (link_req_memtype == `ATG_MT_WB))
		else $error("cacheable flag");
	page_offset_a: assert property (link_req_valid |-> link_req_pa[11:0] == va_reg[11:0])
		else $error("offset");
	issue_time_a: assert property (afu_take ##2 !inv_busy_reg |-> link_req_valid || ats_req_valid)
		else $error("request latency");
	// Main scenarios
	cover property (afu_take ##2 link_req_valid);
	cover property (inv_cpl_valid && inv_cpl_ready);
	cover property (afu_rsp_fault);
endmodule

// >>> bench/atg_host_model.sv
// Host translation agent answering the gate's translation requests
`timescale 1ns/100ps
`include "atg_defs.vh"
module atg_host_model (
	// Clock, reset and answer settings
	input wire clk_sys, nrst, ok_set,
	input wire [1:0] mt_set,
	input wire [2:0] lag,
	// Translation request and completion
	input wire ats_req_valid,
	input wire [35:0] ats_req_vpn,
	output wire ats_req_ready,
	output reg ats_cpl_valid, ats_cpl_ok,
	output reg [2:0] ats_cpl_vc,
	output reg [35:0] ats_cpl_ppn,
	output reg [1:0] ats_cpl_memtype
);
	reg [2:0]  wait_reg;
	reg [35:0] vpn_reg;
	// One translation in flight; PASID prefix not taken, no port for it
	assign ats_req_ready = wait_reg == 3'h0;
	// Answer after lag cycles on channel zero; idle fields toggle
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			{wait_reg, vpn_reg, ats_cpl_valid} <= 40'h0;
			{ats_cpl_vc, ats_cpl_ok, ats_cpl_memtype, ats_cpl_ppn} <= 42'h0;
		end else begin
			ats_cpl_valid <= wait_reg == 3'h1;
			if (wait_reg == 3'h1)
				{ats_cpl_vc, ats_cpl_ok, ats_cpl_memtype, ats_cpl_ppn} <= {3'h0, ok_set, mt_set, vpn_reg + 36'h100};
			else
				{ats_cpl_vc, ats_cpl_ok, ats_cpl_memtype, ats_cpl_ppn} <= ~{ats_cpl_vc, ats_cpl_ok, ats_cpl_memtype, ats_cpl_ppn};
			if (ats_req_valid && ats_req_ready) begin
				wait_reg <= lag;
				vpn_reg <= ats_req_vpn;
			end else if (wait_reg != 3'h0) begin
				wait_reg <= wait_reg - 3'h1;
			end
		end
	end
endmodule

// >>> bench/test_atg_gate.sv
// Testbench for the translation gate
`timescale 1ns/100ps
`include "atg_defs.vh"
module test_atg_gate;
	logic clk_sys, nrst, ce, afu_req_valid, afu_req_ready, afu_req_write, afu_rsp_fault, ats_req_valid, ats_req_ready;
	logic ats_req_pasid_vld, ats_cpl_valid, ats_cpl_ok, inv_req_valid, inv_req_ready, inv_cpl_valid, inv_cpl_ready;
	logic pcie_inv_done, link_req_valid, link_req_ready, link_req_write, link_req_cacheable, link_done_valid, ok_set;
	logic [47:0] afu_req_va, link_req_pa;
	logic [35:0] ats_req_vpn, ats_cpl_ppn, inv_req_vpn, inv_req_mask;
	logic [19:0] afu_req_pasid, ats_req_pasid;
	logic [4:0]  inv_req_tag, inv_cpl_tag;
	logic [2:0]  ats_req_vc, ats_cpl_vc, inv_req_vc, inv_cpl_vc, lag;
	logic [1:0]  ats_cpl_memtype, link_req_memtype, link_req_id, link_done_id, mt_set, last_id;
	int fail_count = 0, checks = 0, ats_n = 0, n0;
	atg_gate atg_gate_i (.*);
	atg_host_model atg_host_model_i (.*);
	// Clock and translation counter
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (ats_req_valid && ats_req_ready) ats_n <= ats_n + 1;
	task automatic chk(input string nm, input logic [47:0] e, g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One accelerator request, judged at the link or by a fault
	task automatic access(input logic [47:0] va, input logic [1:0] mt, input logic ok);
		@(posedge clk_sys);
		afu_req_valid <= 1'b1;
		afu_req_va <= va;
		afu_req_write <= va[4];
		mt_set <= mt;
		ok_set <= ok;
		do @(negedge clk_sys); while (afu_req_ready !== 1'b1);
		@(posedge clk_sys);
		afu_req_valid <= 1'b0;
		if (!ok || mt == 2'h3) begin
			for (int i = 0; i < 20 && afu_rsp_fault !== 1'b1; i++) @(negedge clk_sys);
			chk("fault", 1'b1, afu_rsp_fault);
		end else begin
			for (int i = 0; i < 20 && link_req_valid !== 1'b1; i++) @(negedge clk_sys);
			chk("link valid", 1'b1, link_req_valid);
			chk("link pa", {va[47:12] + 36'h100, va[11:0]}, link_req_pa);
			chk("write", va[4], link_req_write);
			chk("memtype", mt, link_req_memtype);
			last_id = link_req_id;
		end
	endtask
	task automatic done(input logic [1:0] id);
		@(posedge clk_sys);
		link_done_valid <= 1'b1;
		link_done_id <= id;
		@(posedge clk_sys);
		link_done_valid <= 1'b0;
	endtask
	task automatic invalidate(input logic [35:0] vpn, mask, input logic [2:0] vc, input logic [4:0] tag);
		@(posedge clk_sys);
		{inv_req_valid, inv_req_vpn, inv_req_mask, inv_req_vc, inv_req_tag} <= {1'b1, vpn, mask, vc, tag};
		@(posedge clk_sys);
		inv_req_valid <= 1'b0;
	endtask
	// Miss then hit, every memory type, failed translation
	task automatic test_translate;
		access(48'h0000_1234_5abc, 2'h2, 1'b1);
		done(last_id);
		chk("pasid", afu_req_pasid, ats_req_pasid);
		chk("pasid vld", 1'b1, ats_req_pasid_vld);
		n0 = ats_n;
		access(48'h0000_1234_5d10, 2'h2, 1'b1);
		done(last_id);
		chk("hit count", n0, ats_n);
		for (int m = 0; m < 4; m++) begin
			access({32'h0000_0070 + m, 16'h7010}, m[1:0], 1'b1);
			if (m != 3) done(last_id);
		end
		access(48'h0000_0099_9020, 2'h2, 1'b0);
	endtask
	// Completion withheld until drain and other channels finish
	task automatic test_inval;
		@(posedge clk_sys);
		lag <= 3'h6;
		access(48'h0000_1234_5100, 2'h2, 1'b1);
		invalidate(36'h0_1234_5, 36'h0, 3'h0, 5'h15);
		repeat (8) @(negedge clk_sys);
		chk("cpl held", 1'b0, inv_cpl_valid);
		chk("afu ready", 1'b0, afu_req_ready);
		done(last_id);
		repeat (4) @(negedge clk_sys);
		chk("cpl held", 1'b0, inv_cpl_valid);
		@(posedge clk_sys);
		pcie_inv_done <= 1'b1;
		for (int i = 0; i < 20 && inv_cpl_valid !== 1'b1; i++) @(negedge clk_sys);
		chk("cpl seen", 1'b1, inv_cpl_valid);
		chk("cpl tag", 5'h15, inv_cpl_tag);
		chk("cpl vc", 3'h0, inv_cpl_vc);
		n0 = ats_n;
		access(48'h0000_1234_5200, 2'h2, 1'b1);
		done(last_id);
		chk("retranslate", n0 + 1, ats_n);
	endtask
	// Invalidation off channel zero is dropped
	task automatic test_other_vc;
		invalidate(36'h0_1234_5, 36'h0, 3'h1, 5'h03);
		repeat (6) @(negedge clk_sys);
		chk("no cpl", 1'b0, inv_cpl_valid);
		n0 = ats_n;
		access(48'h0000_1234_5300, 2'h2, 1'b1);
		done(last_id);
		chk("still cached", n0, ats_n);
	endtask
	// Masked range purges several pages, others stay cached
	task automatic test_range;
		invalidate(36'h0_0000_707, 36'h0_0000_0f0, 3'h0, 5'h0a);
		for (int i = 0; i < 20 && inv_cpl_valid !== 1'b1; i++) @(negedge clk_sys);
		chk("range cpl", 1'b1, inv_cpl_valid);
		chk("range tag", 5'h0a, inv_cpl_tag);
		n0 = ats_n;
		access(48'h0000_0071_7010, 2'h1, 1'b1);
		done(last_id);
		chk("range purge", n0 + 1, ats_n);
		access(48'h0000_1234_5400, 2'h2, 1'b1);
		done(last_id);
		chk("outside range", n0 + 1, ats_n);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		{nrst, afu_req_valid, afu_req_write, inv_req_valid, pcie_inv_done, link_done_valid} = 6'h0;
		{ce, inv_cpl_ready, link_req_ready, ok_set, lag, mt_set} = 9'h1f2;
		{afu_req_va, inv_req_vpn, inv_req_mask, inv_req_tag, inv_req_vc, link_done_id} = '0;
		afu_req_pasid = 20'h0abcd;
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		test_translate;
		test_inval;
		test_other_vc;
		test_range;
		conclude;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		fail_count++;
		conclude;
	end
endmodule
bind atg_gate atg_gate_checker atg_gate_checker_i (
	.clk_sys(clk_sys), .nrst(nrst),
	.afu_req_valid(afu_req_valid), .afu_req_ready(afu_req_ready), .afu_rsp_fault(afu_rsp_fault),
	.afu_req_va(afu_req_va),
	.ats_req_valid(ats_req_valid), .ats_req_ready(ats_req_ready), .ats_cpl_valid(ats_cpl_valid),
	.ats_cpl_ok(ats_cpl_ok), .ats_req_vc(ats_req_vc), .ats_cpl_vc(ats_cpl_vc),
	.ats_cpl_memtype(ats_cpl_memtype),
	.inv_req_valid(inv_req_valid), .inv_req_ready(inv_req_ready), .inv_cpl_valid(inv_cpl_valid),
	.inv_cpl_ready(inv_cpl_ready), .pcie_inv_done(pcie_inv_done),
	.inv_req_vc(inv_req_vc), .inv_cpl_vc(inv_cpl_vc), .inv_req_tag(inv_req_tag), .inv_cpl_tag(inv_cpl_tag),
	.link_req_valid(link_req_valid), .link_req_cacheable(link_req_cacheable),
	.link_req_pa(link_req_pa), .link_req_memtype(link_req_memtype)
);

// >>> hdl/atg_defs.vh
// Constants for the translation gate: widths, encodings, channel numbers
`ifndef ATG_DEFS_VH
`define ATG_DEFS_VH

// Address layout
`define ATG_VA_W      48
`define ATG_PG_W      12
`define ATG_VPN_W     36
`define ATG_PASID_W   20

// Translation cache geometry
`define ATG_ENT       4
`define ATG_IDX_W     2
`define ATG_CNT_W     4
`define ATG_CNT_MAX   4'hf
`define ATG_CNT_ONE   4'h1

// Memory type carried in translation completions
`define ATG_MT_W      2
`define ATG_MT_DEV    2'h0
`define ATG_MT_NC     2'h1
`define ATG_MT_WB     2'h2
`define ATG_MT_RSVD   2'h3

// Virtual channel numbers
`define ATG_VC_W      3
`define ATG_VC_ATS    3'h0
`define ATG_VC_COH    3'h1
`define ATG_VC_INVCPL 3'h0

// Invalidation tag and PASID prefix option
`define ATG_ITAG_W    5
`define ATG_PASID_EN  1'b1

// Request path states
`define ATG_ST_W      3
`define ATG_ST_IDLE   3'h0
`define ATG_ST_LOOK   3'h1
`define ATG_ST_XREQ   3'h2
`define ATG_ST_XWAIT  3'h3
`define ATG_ST_FILL   3'h4
`define ATG_ST_ISSUE  3'h5

// Invalidation states
`define ATG_IS_W      2
`define ATG_IS_IDLE   2'h0
`define ATG_IS_DRAIN  2'h1
`define ATG_IS_CPL    2'h2

`endif

// >>> hdl/atg_gate.v
// Translation gate between accelerator requests and the coherent link
//
// How it works
// - Only physical addresses go onto the link.
// - Accelerator virtual addresses get translated before use.
// - Cache sees only physical line addresses.
// - All translation traffic uses virtual channel zero.
// - Invalidation completions never on coherent channel.
// - PASID prefix support here is a build option.
// - Hold completion until other channels' conditions met.
// - Purge matching translations before completing invalidation.
// - Block new requests on purged translations.
// - Outstanding cacheable requests finish into cache first.
// - Outstanding device and non-cacheable requests finish first.
// - Invalidation leaves data cache lines untouched.
// - Completion memory type picks link operations, cacheability.
`timescale 1ns/100ps
`include "atg_defs.vh"

module atg_gate (
	// Clock, reset, enable
	input  wire                      clk_sys,
	input  wire                      nrst,
	input  wire                      ce,
	// Accelerator request port
	input  wire                      afu_req_valid,
	output wire                      afu_req_ready,
	input  wire [`ATG_VA_W-1:0]      afu_req_va,
	input  wire                      afu_req_write,
	input  wire [`ATG_PASID_W-1:0]   afu_req_pasid,
	output reg                       afu_rsp_fault,
	// Translation request to host
	output wire                      ats_req_valid,
	input  wire                      ats_req_ready,
	output wire [`ATG_VPN_W-1:0]     ats_req_vpn,
	output wire [`ATG_PASID_W-1:0]   ats_req_pasid,
	output wire                      ats_req_pasid_vld,
	output wire [`ATG_VC_W-1:0]      ats_req_vc,
	// Translation completion from host
	input  wire                      ats_cpl_valid,
	input  wire [`ATG_VC_W-1:0]      ats_cpl_vc,
	input  wire                      ats_cpl_ok,
	input  wire [`ATG_VPN_W-1:0]     ats_cpl_ppn,
	input  wire [`ATG_MT_W-1:0]      ats_cpl_memtype,
	// Invalidation request from host
	input  wire                      inv_req_valid,
	output wire                      inv_req_ready,
	input  wire [`ATG_VC_W-1:0]      inv_req_vc,
	input  wire [`ATG_VPN_W-1:0]     inv_req_vpn,
	input  wire [`ATG_VPN_W-1:0]     inv_req_mask,
	input  wire [`ATG_ITAG_W-1:0]    inv_req_tag,
	// Invalidation completion to host
	output wire                      inv_cpl_valid,
	input  wire                      inv_cpl_ready,
	output reg  [`ATG_ITAG_W-1:0]    inv_cpl_tag,
	output wire [`ATG_VC_W-1:0]      inv_cpl_vc,
	// Other channels report their invalidation conditions met
	input  wire                      pcie_inv_done,
	// Physical request to the requesting_agent link side
	output wire                      link_req_valid,
	input  wire                      link_req_ready,
	output wire [`ATG_VA_W-1:0]      link_req_pa,
	output reg                       link_req_write,
	output reg  [`ATG_MT_W-1:0]      link_req_memtype,
	output wire                      link_req_cacheable,
	output reg  [`ATG_IDX_W-1:0]     link_req_id,
	// Request finished: cacheable into cache, others completed
	input  wire                      link_done_valid,
	input  wire [`ATG_IDX_W-1:0]     link_done_id
);

	// Translation cache storage
	reg  [`ATG_VPN_W-1:0]   tag_vpn   [0:`ATG_ENT-1];
	reg  [`ATG_PASID_W-1:0] tag_pasid [0:`ATG_ENT-1];
	reg  [`ATG_VPN_W-1:0]   ent_ppn   [0:`ATG_ENT-1];
	reg  [`ATG_MT_W-1:0]    ent_mt    [0:`ATG_ENT-1];
	reg  [`ATG_CNT_W-1:0]   ent_cnt   [0:`ATG_ENT-1];
	reg  [`ATG_ENT-1:0]     ent_vld_reg;
	reg  [`ATG_ENT-1:0]     drain_reg;

	// Request path and invalidation holding state
	reg  [`ATG_ST_W-1:0]    st_reg;
	reg  [`ATG_IS_W-1:0]    inv_st_reg;
	reg  [`ATG_VPN_W-1:0]   hold_vpn_reg;
	reg  [`ATG_PG_W-1:0]    hold_off_reg;
	reg  [`ATG_PASID_W-1:0] hold_pasid_reg;
	reg  [`ATG_VPN_W-1:0]   hold_ppn_reg;

	wire [`ATG_ENT-1:0]     hit_vec;
	wire [`ATG_ENT-1:0]     inv_vec;
	wire [`ATG_ENT-1:0]     busy_vec;
	reg                     hit;
	reg  [`ATG_IDX_W-1:0]   hit_idx;
	reg                     vic_ok;
	reg  [`ATG_IDX_W-1:0]   vic_idx;
	integer                 i;
	integer                 j; // Own loop index for the clocked entry process

	wire inv_busy  = (inv_st_reg != `ATG_IS_IDLE);
	wire inv_take  = inv_req_valid && (inv_st_reg == `ATG_IS_IDLE);
	wire inv_vc_ok = (inv_req_vc == `ATG_VC_ATS);
	wire cpl_take  = ats_cpl_valid && (ats_cpl_vc == `ATG_VC_ATS) && (st_reg == `ATG_ST_XWAIT);
	wire mt_bad    = (ats_cpl_memtype == `ATG_MT_RSVD);
	wire issue_go  = link_req_valid && link_req_ready;

	// Per-entry lookup, range match and drain status
	genvar g;
	generate
		for (g = 0; g < `ATG_ENT; g = g + 1) begin : g_ent
			assign hit_vec[g]  = ent_vld_reg[g] && (tag_vpn[g] == hold_vpn_reg) &&
				(tag_pasid[g] == hold_pasid_reg);
			assign inv_vec[g]  = (((tag_vpn[g] ^ inv_req_vpn) & ~inv_req_mask) == {`ATG_VPN_W{1'b0}});
			assign busy_vec[g] = drain_reg[g] && (ent_cnt[g] != {`ATG_CNT_W{1'b0}});
		end
	endgenerate

	// Hit encode and victim choice; draining slots are never reused
	always @* begin
		hit = 1'b0;
		hit_idx = {`ATG_IDX_W{1'b0}};
		vic_ok = 1'b0;
		vic_idx = {`ATG_IDX_W{1'b0}};
		for (i = `ATG_ENT - 1; i >= 0; i = i - 1) begin
			if (hit_vec[i]) begin
				hit = 1'b1;
				hit_idx = i[`ATG_IDX_W-1:0];
			end
			if (ent_cnt[i] == {`ATG_CNT_W{1'b0}} && ent_vld_reg[i]) begin
				vic_ok = 1'b1;
				vic_idx = i[`ATG_IDX_W-1:0];
			end
		end
		for (i = `ATG_ENT - 1; i >= 0; i = i - 1) begin
			if (ent_cnt[i] == {`ATG_CNT_W{1'b0}} && !ent_vld_reg[i]) begin
				vic_ok = 1'b1;
				vic_idx = i[`ATG_IDX_W-1:0];
			end
		end
	end

	// Handshakes
	assign afu_req_ready      = (st_reg == `ATG_ST_IDLE) && !inv_busy;
	assign ats_req_valid      = (st_reg == `ATG_ST_XREQ);
	assign ats_req_vpn        = hold_vpn_reg;
	assign ats_req_pasid      = `ATG_PASID_EN ? hold_pasid_reg : {`ATG_PASID_W{1'b0}};
	assign ats_req_pasid_vld  = `ATG_PASID_EN;
	assign ats_req_vc         = `ATG_VC_ATS;
	assign inv_req_ready      = (inv_st_reg == `ATG_IS_IDLE);
	assign inv_cpl_valid      = (inv_st_reg == `ATG_IS_CPL);
	assign inv_cpl_vc         = `ATG_VC_INVCPL;
	// Issue only a translated slot, never during an invalidation
	assign link_req_valid     = (st_reg == `ATG_ST_ISSUE) && !inv_busy &&
		(ent_cnt[link_req_id] != `ATG_CNT_MAX);
	assign link_req_pa        = {hold_ppn_reg, hold_off_reg};
	assign link_req_cacheable = (link_req_memtype == `ATG_MT_WB);

	// Request path: look up, translate, fill, issue
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_reg <= `ATG_ST_IDLE;
			hold_vpn_reg <= {`ATG_VPN_W{1'b0}};
			hold_off_reg <= {`ATG_PG_W{1'b0}};
			hold_pasid_reg <= {`ATG_PASID_W{1'b0}};
			hold_ppn_reg <= {`ATG_VPN_W{1'b0}};
			link_req_write <= 1'b0;
			link_req_memtype <= `ATG_MT_DEV;
			link_req_id <= {`ATG_IDX_W{1'b0}};
			afu_rsp_fault <= 1'b0;
		end else if (ce) begin
			afu_rsp_fault <= 1'b0;
			case (st_reg)
				`ATG_ST_IDLE: begin
					if (afu_req_valid && afu_req_ready) begin
						hold_vpn_reg <= afu_req_va[`ATG_VA_W-1:`ATG_PG_W];
						hold_off_reg <= afu_req_va[`ATG_PG_W-1:0];
						hold_pasid_reg <= `ATG_PASID_EN ? afu_req_pasid : {`ATG_PASID_W{1'b0}};
						link_req_write <= afu_req_write;
						st_reg <= `ATG_ST_LOOK;
					end
				end
				`ATG_ST_LOOK: begin
					if (!inv_busy && hit) begin
						hold_ppn_reg <= ent_ppn[hit_idx];
						link_req_memtype <= ent_mt[hit_idx];
						link_req_id <= hit_idx;
						st_reg <= `ATG_ST_ISSUE;
					end else if (!inv_busy) begin
						st_reg <= `ATG_ST_XREQ;
					end
				end
				`ATG_ST_XREQ: begin
					if (ats_req_ready)
						st_reg <= `ATG_ST_XWAIT;
				end
				`ATG_ST_XWAIT: begin
					if (cpl_take && (!ats_cpl_ok || mt_bad)) begin
						afu_rsp_fault <= 1'b1;
						st_reg <= `ATG_ST_IDLE;
					end else if (cpl_take) begin
						hold_ppn_reg <= ats_cpl_ppn;
						link_req_memtype <= ats_cpl_memtype;
						st_reg <= `ATG_ST_FILL;
					end
				end
				`ATG_ST_FILL: begin
					if (inv_busy)
						st_reg <= `ATG_ST_LOOK;
					else if (vic_ok && !inv_take) begin
						link_req_id <= vic_idx;
						st_reg <= `ATG_ST_ISSUE;
					end
				end
				`ATG_ST_ISSUE: begin
					if (inv_busy)
						st_reg <= `ATG_ST_LOOK;
					else if (issue_go)
						st_reg <= `ATG_ST_IDLE;
				end
				default: st_reg <= `ATG_ST_IDLE;
			endcase
		end
	end

	// Cache entries: fill, purge, outstanding counts
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ent_vld_reg <= {`ATG_ENT{1'b0}};
			drain_reg <= {`ATG_ENT{1'b0}};
			for (j = 0; j < `ATG_ENT; j = j + 1) begin
				tag_vpn[j] <= {`ATG_VPN_W{1'b0}};
				tag_pasid[j] <= {`ATG_PASID_W{1'b0}};
				ent_ppn[j] <= {`ATG_VPN_W{1'b0}};
				ent_mt[j] <= `ATG_MT_DEV;
				ent_cnt[j] <= {`ATG_CNT_W{1'b0}};
			end
		end else if (ce) begin
			for (j = 0; j < `ATG_ENT; j = j + 1) begin
				if (issue_go && link_req_id == j && !(link_done_valid && link_done_id == j))
					ent_cnt[j] <= ent_cnt[j] + `ATG_CNT_ONE;
				else if (!(issue_go && link_req_id == j) && link_done_valid && link_done_id == j)
					ent_cnt[j] <= ent_cnt[j] - `ATG_CNT_ONE;
			end
			if (st_reg == `ATG_ST_FILL && !inv_busy && vic_ok && !inv_take) begin
				tag_vpn[vic_idx] <= hold_vpn_reg;
				tag_pasid[vic_idx] <= hold_pasid_reg;
				ent_ppn[vic_idx] <= hold_ppn_reg;
				ent_mt[vic_idx] <= link_req_memtype;
				ent_vld_reg[vic_idx] <= 1'b1;
			end
			// Purge the range; data cache lines are left alone
			if (inv_take && inv_vc_ok) begin
				ent_vld_reg <= ent_vld_reg & ~inv_vec;
				drain_reg <= inv_vec;
			end else if (inv_st_reg == `ATG_IS_CPL)
				drain_reg <= {`ATG_ENT{1'b0}};
		end
	end

	// Invalidation: purge, wait for drains, then complete
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			inv_st_reg <= `ATG_IS_IDLE;
			inv_cpl_tag <= {`ATG_ITAG_W{1'b0}};
		end else if (ce) begin
			case (inv_st_reg)
				`ATG_IS_IDLE: begin
					if (inv_take && inv_vc_ok) begin
						inv_cpl_tag <= inv_req_tag;
						inv_st_reg <= `ATG_IS_DRAIN;
					end
				end
				`ATG_IS_DRAIN: begin
					if (busy_vec == {`ATG_ENT{1'b0}} && pcie_inv_done)
						inv_st_reg <= `ATG_IS_CPL;
				end
				`ATG_IS_CPL: begin
					if (inv_cpl_ready)
						inv_st_reg <= `ATG_IS_IDLE;
				end
				default: inv_st_reg <= `ATG_IS_IDLE;
			endcase
		end
	end

endmodule
